//--- logic/srap_port.sv
// srap_port: serial register access port, top level
// assumes: register file attached on clk side; link clock from the host
`timescale 1ns/1ps
module srap_port
  import srap_pkg::*;
(
  // system
  input  wire logic       clk,
  input  wire logic       srst,
  // mode pins
  input  wire logic       interface_select_pin,
  input  wire logic       parallel_style_pin,
  output logic            serial_mode,
  output logic            parallel_mux_mode,
  // serial link
  input  wire logic       serial_clock_in,
  input  wire logic       cs_n,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_en,
  // register file access
  output logic [4:0]      read_target,
  output logic            reg_rd,
  output logic            reg_rd_clear,
  input  wire logic [7:0] reg_rdata,
  output logic [4:0]      write_target,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata
);
  srap_xfer_if xfer ();

  logic       link_cs_n;
  logic [1:0] mode_sync;
  logic [1:0] style_sync;
  logic [1:0] frame_sync;
  logic [2:0] rx_sync;
  logic       rx_event;
  logic       frame_on;
  logic       tx_tog;
  logic [7:0] tx_data;
  logic [1:0] cmd;
  logic [4:0] target;
  logic       load_pend;
  logic       load_clear;
  srap_phase_t phase;
  srap_phase_t next_phase;

  // parallel mode forces the serial port idle
  assign link_cs_n = cs_n | ~interface_select_pin;

  srap_shifter u_shift
  (
    .serial_clock_in (serial_clock_in),
    .cs_n            (link_cs_n),
    .serial_in       (serial_in),
    .serial_out      (serial_out),
    .xfer            (xfer.link)
  );

  assign serial_out_en = ~link_cs_n;
  assign xfer.tx_toggle = tx_tog;
  assign xfer.tx_byte   = tx_data;

  // mode pin synchronisers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_sync  <= 2'h0;
      style_sync <= 2'h0;
    end
    else
    begin
      mode_sync  <= {mode_sync[0], interface_select_pin};
      style_sync <= {style_sync[0], parallel_style_pin};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      serial_mode       <= 1'b0;
      parallel_mux_mode <= 1'b0;
    end
    else
    begin
      serial_mode       <= mode_sync[1];
      parallel_mux_mode <= ~mode_sync[1] & style_sync[1];
    end
  end

  // link events into the clk domain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frame_sync <= 2'h0;
      rx_sync    <= 3'h0;
    end
    else
    begin
      frame_sync <= {frame_sync[0], xfer.frame_active};
      rx_sync    <= {rx_sync[1:0], xfer.rx_toggle};
    end
  end

  assign frame_on = frame_sync[1];
  assign rx_event = rx_sync[2] ^ rx_sync[1];

  always_comb
  begin
    next_phase = phase;
    case (phase)
      SRAP_IDLE:
        if (frame_on)
          next_phase = SRAP_CMD;
      SRAP_CMD:
        if (!frame_on)
          next_phase = SRAP_IDLE;
        else if (rx_event && (xfer.rx_byte[CMD_MSB:CMD_LSB] == CMD_WRITE
                              || xfer.rx_byte[CMD_MSB:CMD_LSB] == CMD_BURST))
          next_phase = SRAP_WDATA;
      SRAP_WDATA:
        if (!frame_on)
          next_phase = SRAP_IDLE;
        else if (rx_event && cmd == CMD_WRITE)
          next_phase = SRAP_CMD;
      SRAP_HOLD:
        next_phase = SRAP_IDLE;
      default:
        next_phase = SRAP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      phase <= SRAP_IDLE;
    else
      phase <= next_phase;
  end

  // command and target capture
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd    <= CMD_NOP;
      target <= ADDR_ZERO;
    end
    else if (phase == SRAP_CMD && rx_event)
    begin
      cmd    <= xfer.rx_byte[CMD_MSB:CMD_LSB];
      target <= xfer.rx_byte[ADDR_MSB:0];
    end
  end

  // register writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_wr       <= 1'b0;
      reg_wdata    <= BYTE_ZERO;
      write_target <= ADDR_ZERO;
    end
    else
    begin
      reg_wr <= phase == SRAP_WDATA && rx_event && frame_on;
      if (phase == SRAP_WDATA && rx_event)
      begin
        reg_wdata    <= xfer.rx_byte;
        write_target <= target;
      end
    end
  end

  // read requests: after a read command, or after each write unless frame_on is already low in the next cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      load_pend  <= 1'b0;
      load_clear <= 1'b0;
      read_target <= ADDR_ZERO;
    end
    else if (!frame_on)
    begin
      load_pend  <= 1'b0;
      load_clear <= 1'b0;
    end
    else if (phase == SRAP_CMD && rx_event
             && xfer.rx_byte[CMD_MSB:CMD_LSB] == CMD_READ)
    begin
      load_pend   <= 1'b1;
      load_clear  <= 1'b1;
      read_target <= xfer.rx_byte[ADDR_MSB:0];
    end
    else if (reg_wr)
    begin
      load_pend   <= 1'b1;
      load_clear  <= 1'b0;
      read_target <= write_target;
    end
    else
      load_pend <= 1'b0;
  end

  assign reg_rd       = load_pend;
  assign reg_rd_clear = load_pend & load_clear;

  // read data latched for the next outgoing byte; no-op leaves it alone
  // transmit data registers may hand back junk here, which is tolerated
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_data <= BYTE_ZERO;
      tx_tog  <= 1'b0;
    end
    else if (load_pend)
    begin
      tx_data <= reg_rdata;
      tx_tog  <= ~tx_tog;
    end
  end
endmodule

//--- logic/srap_pkg.sv
// srap_pkg: constants shared by the serial register access port files
// assumes: byte-wide internal register file with a 5-bit address space
package srap_pkg;
  localparam int unsigned BYTE_BITS   = 8;
  localparam int unsigned ADDR_BITS   = 5;
  localparam int unsigned CMD_MSB     = 7;
  localparam int unsigned CMD_LSB     = 6;
  localparam int unsigned ADDR_MSB    = 4;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [1:0]  CMD_READ    = 2'h0;
  localparam logic [1:0]  CMD_NOP     = 2'h1;
  localparam logic [1:0]  CMD_WRITE   = 2'h2;
  localparam logic [1:0]  CMD_BURST   = 2'h3;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [4:0]  ADDR_ZERO   = 5'h00;

  // command phase of the register-side sequencer
  typedef enum logic [3:0]
  {
    SRAP_IDLE  = 4'h1,
    SRAP_CMD   = 4'h2,
    SRAP_WDATA = 4'h4,
    SRAP_HOLD  = 4'h8
  } srap_phase_t;
endpackage

//--- logic/srap_xfer_if.sv
// srap_xfer_if: byte events between the link shifter and the sequencer
// assumes: byte carries a gray-free toggle handshake, frame a plain level; data held stable
`timescale 1ns/1ps
interface srap_xfer_if;
  logic       rx_toggle;
  logic [7:0] rx_byte;
  logic       tx_toggle;
  logic [7:0] tx_byte;
  logic       frame_active;

  modport link
  (
    output rx_toggle,
    output rx_byte,
    output frame_active,
    input  tx_toggle,
    input  tx_byte
  );

  modport core
  (
    input  rx_toggle,
    input  rx_byte,
    input  frame_active,
    output tx_toggle,
    output tx_byte
  );
endinterface

//--- logic/srap_shifter.sv
// srap_shifter: link-side serial shift logic on the host serial clock
// assumes: cs_n synchronous to the host clock; next byte offered before use
`timescale 1ns/1ps
module srap_shifter
  import srap_pkg::*;
(
  // link pins
  input  wire logic serial_clock_in,
  input  wire logic cs_n,
  input  wire logic serial_in,
  output logic      serial_out,
  // towards the core
  srap_xfer_if.link xfer
);
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] rx_hold;
  // powers up low and is never cleared by cs_n, so a frame end makes no false edge
  logic       rx_tog = 1'b0;
  logic       rx_done;
  logic       loaded;

  // cs_n high holds the shifter in reset
  always_ff @(posedge serial_clock_in or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt  <= BIT_FIRST;
      shift_in <= BYTE_ZERO;
    end
    else
    begin
      shift_in <= {shift_in[6:0], serial_in};
      bit_cnt  <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge serial_clock_in or posedge cs_n)
  begin
    if (cs_n)
      rx_done <= 1'b0;
    else
      rx_done <= (bit_cnt == BIT_LAST);
  end

  // byte handed over on falling edge after the eighth rising edge
  always_ff @(negedge serial_clock_in)
  begin
    if (!cs_n && rx_done)
    begin
      rx_hold <= shift_in;
      rx_tog  <= ~rx_tog;
    end
  end

  // a fresh byte shows its msb straight from the core's held byte, so the
  // read fetched in the gap after the eighth falling edge is what goes out
  always_ff @(negedge serial_clock_in or posedge cs_n)
  begin
    if (cs_n)
    begin
      shift_out <= BYTE_ZERO;
      loaded    <= 1'b0;
    end
    else if (rx_done)
      loaded <= 1'b0;
    else if (!loaded)
    begin
      shift_out <= {xfer.tx_byte[6:0], 1'b0};
      loaded    <= 1'b1;
    end
    else
      shift_out <= {shift_out[6:0], 1'b0};
  end

  assign serial_out        = loaded ? shift_out[CMD_MSB] : xfer.tx_byte[CMD_MSB];
  assign xfer.rx_byte      = rx_hold;
  assign xfer.rx_toggle    = rx_tog;
  assign xfer.frame_active = ~cs_n;
endmodule

//--- tb/srap_port_assertions.sv
// srap_port_assertions: clk-side checks on srap_port pins
// assumes: bound onto srap_port
`timescale 1ns/1ps
module srap_port_assertions
(
  // watched pins
  input wire logic clk,
  input wire logic srst,
  input wire logic interface_select_pin,
  input wire logic parallel_style_pin,
  input wire logic serial_mode,
  input wire logic parallel_mux_mode,
  input wire logic cs_n,
  input wire logic serial_out_en,
  input wire logic reg_rd,
  input wire logic reg_rd_clear,
  input wire logic reg_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rb;
    reg_rd && !reg_rd_clear;
  endsequence
  property p_sel;
    $rose(interface_select_pin) |-> ##[1:4] serial_mode;
  endproperty
  a_sel: assert property (p_sel) else $error("serial mode late");
  property p_mux;
    (!interface_select_pin && parallel_style_pin)[*5] |-> parallel_mux_mode;
  endproperty
  a_mux: assert property (p_mux) else $error("mux mode missing");
  property p_en;
    (!cs_n && interface_select_pin)[*2] |-> serial_out_en;
  endproperty
  a_en: assert property (p_en) else $error("output not enabled");
  property p_rd;
    reg_rd |=> !reg_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe long");
  property p_wr;
    reg_wr |=> !reg_wr;
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe long");
  property p_rb;
    reg_wr |-> ##[0:4] s_rb;
  endproperty
  a_rb: assert property (p_rb) else $error("no read-back");
  property p_wnc;
    reg_wr |-> !reg_rd_clear;
  endproperty
  a_wnc: assert property (p_wnc) else $error("write clears");
  property p_clr;
    reg_rd_clear |-> reg_rd;
  endproperty
  a_clr: assert property (p_clr) else $error("clear without read");
endmodule
bind srap_port srap_port_assertions u_chk
(
  .clk(clk), .srst(srst), .interface_select_pin(interface_select_pin),
  .parallel_style_pin(parallel_style_pin), .serial_mode(serial_mode),
  .parallel_mux_mode(parallel_mux_mode), .cs_n(cs_n), .serial_out_en(serial_out_en),
  .reg_rd(reg_rd), .reg_rd_clear(reg_rd_clear), .reg_wr(reg_wr)
);

//--- tb/srap_host_model.sv
// srap_host_model: serial bus master driving frames into the port
// assumes: clock idles low, stands still outside frames
`timescale 1ns/1ps
module srap_host_model
(
  // bench timing
  input  wire logic clk,
  // serial link
  input  wire logic serial_out,
  output logic      serial_clock_in,
  output logic      cs_n,
  output logic      serial_in
);
  logic [7:0] tx [4];
  logic [7:0] rx [4];
  initial
  begin
    serial_clock_in = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // nbits below 8*n and not a multiple of 8 cuts the frame mid-byte
  task automatic run(input int n, input int nbits);
    int k;
    k = 0;
    @(negedge clk);
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < n && k < nbits; i++)
    begin
      for (int b = 7; b >= 0 && k < nbits; b--)
      begin
        serial_in = tx[i][b];
        #7.5 serial_clock_in = 1'b1;
        rx[i][b] = serial_out;
        #7.5 serial_clock_in = 1'b0;
        k++;
      end
      // gap lets the core fetch the next byte
      #200;
    end
    serial_in = ~serial_in;
    cs_n = 1'b1;
    #100;
  endtask
endmodule

//--- tb/tb_serial_register_access_port.sv
// tb_serial_register_access_port: random and corner frames through srap_port
// assumes: bench holds the register file on the clk side
`timescale 1ns/1ps
module tb_serial_register_access_port;
  import srap_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       sel = 1'b1;
  logic       sty = 1'b0;
  logic       smode, mmode, sck, cs_n, sdi, sdo, sdo_en, rd, rdc, wr;
  logic [4:0] rt, wt, a;
  logic [7:0] wdata;
  logic [7:0] mem [32];
  logic [7:0] shadow [32];
  logic [7:0] d [4];
  int         num_errors = 0;
  int         total_checks = 0;
  int         nwr = 0;
  int         nclr = 0;
  int         n0, c0;
  int         seed = 32'h60b5;
  wire  [7:0] rdata = mem[rt];
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    if (wr)
    begin
      mem[wt] <= wdata;
      nwr <= nwr + 1;
    end
    if (rdc)
      nclr <= nclr + 1;
  end
  srap_port uut
  (
    .clk(clk), .srst(srst), .interface_select_pin(sel), .parallel_style_pin(sty),
    .serial_mode(smode), .parallel_mux_mode(mmode), .serial_clock_in(sck), .cs_n(cs_n),
    .serial_in(sdi), .serial_out(sdo), .serial_out_en(sdo_en), .read_target(rt),
    .reg_rd(rd), .reg_rd_clear(rdc), .reg_rdata(rdata), .write_target(wt),
    .reg_wr(wr), .reg_wdata(wdata)
  );
  srap_host_model h
  (
    .clk(clk), .serial_out(sdo), .serial_clock_in(sck), .cs_n(cs_n), .serial_in(sdi)
  );
  function automatic logic [7:0] cmd(input logic [1:0] c, input logic [4:0] ad);
    return {c, 1'b0, ad};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    for (int m = 0; m < 4; m++)
    begin
      {sel, sty} = 2'(m);
      repeat (6) @(negedge clk);
      check({7'h00, smode}, {7'h00, sel});
      check({7'h00, mmode}, {7'h00, !sel && sty});
    end
    for (int t = 0; t < 6; t++)
    begin
      // both ends of the address field first
      a = (t == 0) ? 5'h00 : (t == 1) ? 5'h1f : 5'($random(seed));
      d[0] = 8'($random(seed));
      h.tx[0] = cmd(CMD_WRITE, a);
      h.tx[1] = d[0];
      h.run(2, 16);
      check(wdata, d[0]);
      check({3'h0, wt}, {3'h0, a});
      c0 = nclr;
      shadow[a] = d[0];
      // a neighbour read first, so the read of a cannot pass on stale data
      h.tx[0] = cmd(CMD_READ, a ^ 5'h01);
      h.tx[1] = cmd(CMD_READ, a);
      h.tx[2] = cmd(CMD_NOP, a);
      h.tx[3] = cmd(CMD_NOP, a);
      h.run(4, 32);
      check(h.rx[0], d[0]);
      check(h.rx[1], shadow[a ^ 5'h01]);
      check(h.rx[2], d[0]);
      check(h.rx[3], d[0]);
      check(8'(nclr - c0), 8'h02);
    end
    a = 5'h0c;
    h.tx[0] = cmd(CMD_BURST, a);
    for (int i = 1; i < 4; i++)
    begin
      d[i] = 8'($random(seed));
      h.tx[i] = d[i];
    end
    n0 = nwr;
    h.run(4, 32);
    check(h.rx[2], d[1]);
    check(h.rx[3], d[2]);
    check(mem[a], d[3]);
    check(8'(nwr - n0), 8'h03);
    n0 = nwr;
    h.tx[0] = cmd(CMD_WRITE, 5'h03);
    h.tx[1] = 8'h5a;
    h.run(2, 12);
    h.tx[1] = 8'ha5;
    h.run(2, 16);
    check(8'(nwr - n0), 8'h01);
    check(h.rx[0], d[3]);
    check(mem[3], 8'ha5);
    wrap_up();
  end
  initial
  begin
    #1000000;
    num_errors++;
    wrap_up();
  end
endmodule
